// File: msg_cfg_pkg.sv
/*
  Shared constants and types for the message device configuration block.
  Assumes a single 100 MHz core clock and a plain strobe-style register port.
*/
package msg_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_REPLY   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_CAPS    = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG  = 8'h10;

  // Command word fields
  localparam int OP_LSB  = 24;
  localparam int MSK_LSB = 8;

  // Command opcodes
  localparam logic [7:0] OP_ABORT_NORMAL  = 8'h01;
  localparam logic [7:0] OP_BEGIN_NORMAL  = 8'h02;
  localparam logic [7:0] OP_CLEAR         = 8'h03;
  localparam logic [7:0] OP_END_NORMAL    = 8'h04;
  localparam logic [7:0] OP_READ_PROTO    = 8'h05;
  localparam logic [7:0] OP_READ_PERR     = 8'h06;
  localparam logic [7:0] OP_IDENT_COMMANDER_CAPABILITY_BIT    = 8'h07;
  localparam logic [7:0] OP_READ_SERVANTS = 8'h08;
  localparam logic [7:0] OP_GRANT         = 8'h09;
  localparam logic [7:0] OP_RELEASE       = 8'h0A;
  localparam logic [7:0] OP_READ_HANDLERS = 8'h0B;
  localparam logic [7:0] OP_READ_HLINE    = 8'h0C;
  localparam logic [7:0] OP_ASSIGN_HLINE  = 8'h0D;
  localparam logic [7:0] OP_READ_INTRS    = 8'h0E;
  localparam logic [7:0] OP_READ_ILINE    = 8'h0F;
  localparam logic [7:0] OP_ASSIGN_ILINE  = 8'h10;
  localparam logic [7:0] OP_ASYNC_MODE    = 8'h11;
  localparam logic [7:0] OP_CTRL_RESPONSE = 8'h12;
  localparam logic [7:0] OP_CTRL_EVENT    = 8'h13;

  // Protocol error codes
  localparam logic [7:0] PERR_NONE    = 8'h00;
  localparam logic [7:0] PERR_BAD_CMD = 8'h01;

  // Capability register positions and reset value
  localparam int CAP_MASTER     = 0;
  localparam int CAP_COMMANDER_CAPABILITY_BIT       = 1;
  localparam int CAP_PROG_HNDLR = 2;
  localparam int CAP_PROG_INTR  = 3;
  localparam int CAP_RESP_GEN   = 4;
  localparam int CAP_EVENT_GEN  = 5;
  localparam int CAP_AREA_LSB   = 8;
  localparam int CAP_EVSUP_LSB  = 16;
  localparam int CAP_RSSUP_LSB  = 24;
  localparam logic [31:0] CAPS_RESET = 32'h7FFF_043F;

  // Default configuration values
  localparam logic [7:0] DEFAULT_DEST_LA = 8'h00;
  localparam logic [7:0] DEFAULT_COMMANDER_CAPABILITY_BIT_LA = 8'h00;
  localparam logic [2:0] LINE_NONE       = 3'h0;
  localparam logic [6:0] RESP_EN_RESET   = 7'h00;
  localparam logic [7:0] NUM_HANDLERS    = 8'h01;
  localparam logic [7:0] NUM_INTRS       = 8'h01;
  localparam logic [8:0] COUNT_ZERO      = 9'h000;

  typedef enum logic [2:0] {
    ST_CONFIGURE  = 3'b001,
    ST_INITIALIZE = 3'b010,
    ST_NORMAL     = 3'b100
  } substate_e;

  typedef struct packed {
    logic       resp_global;
    logic       evt_global;
    logic       via_signal;
    logic [7:0] dest_la;
    logic [7:0] commander_la;
    logic [2:0] handler_line;
    logic [2:0] intr_line;
    logic [6:0] resp_en;
    logic [7:0] evt_en;
  } cfg_s;

endpackage : msg_cfg_pkg

// File: message_device_config_commands.sv
/*
  Command interpreter and configuration store of a message based device.
  Assumes commands arrive one at a time as writes to the command register,
  already assembled by the word serial transfer logic; replies are read back.
*/
// The strobed register port and the register addresses were decided locally.
// Overview of operation
// - Core commands accepted in configure and normal
// - Bus masters accept identify commander in configure
// - Commanders handle servant area, grant, release in configure
// - Handler reads anytime, assign only configuring
// - Interrupter reads anytime, assign only configuring
// - Response/event output needs matching capability
// - Response capable: async mode, control response
// - Control response toggles each supported transition
// - Event capable: async mode, control event
// - Control event toggles each supported event
// - Reset or abort loads default, configure
// - Default servant list is empty
// - Default: globally enabled, all supported events enabled
// - Master default: signals to address zero
// - Non-master default: deliver via interrupts
// - Default: no interrupt lines connected
// - Default: all response transitions disabled
// - Default: no incoming signal processing (code: incoming always accepted in normal, whatever the config)
// - Config takes effect only in normal operation
// - Grant adds, release removes servant
// - Identify commander records commander address
// - Assign line commands connect the line
// - Configure: no interrupts, no bus transfers
`timescale 1ns/1ps
module message_device_config_commands (
  input  wire logic                           i_core_clk,
  input  wire logic                           i_reset_n,
  input  wire logic [msg_cfg_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [msg_cfg_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [msg_cfg_pkg::DATA_W-1:0] o_rdata,
  output msg_cfg_pkg::substate_e              o_substate,
  output logic                                o_activated,
  output logic                                o_accept_incoming,
  output logic      [2:0]                     o_irq_line,
  output logic      [2:0]                     o_handler_line,
  output logic                                o_deliver_via_signal,
  output logic      [7:0]                     o_dest_la,
  output logic      [6:0]                     o_resp_gen_en,
  output logic      [7:0]                     o_evt_gen_en
);
  import msg_cfg_pkg::*;

  substate_e   state;
  substate_e   next_state;
  cfg_s        cfg;
  cfg_s        dflt;
  logic [31:0] caps;
  logic [7:0]  perr;
  logic [15:0] reply;
  logic        reply_valid;
  logic        servant_list [0:255];
  logic [8:0]  servant_count;

  logic        wr_cmd;
  logic        rd_reply;
  logic [7:0]  op;
  logic [7:0]  arg;
  logic [7:0]  msk;
  logic        legal;

  assign wr_cmd   = i_wr && (i_addr == ADDR_COMMAND);
  assign rd_reply = i_rd && (i_addr == ADDR_REPLY);
  assign op       = i_wdata[OP_LSB +: 8];
  assign arg      = i_wdata[7:0];
  assign msk      = i_wdata[MSK_LSB +: 8];

  // Acceptance table per sub-state and capability
  function automatic logic cmd_legal(input logic [7:0] code, input substate_e st,
                                     input logic [31:0] cp);
    logic cfg_st;
    logic any_st;
    cfg_st = (st == ST_CONFIGURE);
    any_st = (st == ST_CONFIGURE) || (st == ST_NORMAL);
    case (code)
      OP_ABORT_NORMAL, OP_BEGIN_NORMAL, OP_CLEAR,
      OP_END_NORMAL, OP_READ_PROTO, OP_READ_PERR: cmd_legal = any_st;
      OP_IDENT_COMMANDER_CAPABILITY_BIT:    cmd_legal = cfg_st && cp[CAP_MASTER];
      OP_READ_SERVANTS, OP_GRANT,
      OP_RELEASE:       cmd_legal = cfg_st && cp[CAP_COMMANDER_CAPABILITY_BIT];
      OP_READ_HANDLERS,
      OP_READ_HLINE:    cmd_legal = any_st && cp[CAP_PROG_HNDLR];
      OP_ASSIGN_HLINE:  cmd_legal = cfg_st && cp[CAP_PROG_HNDLR];
      OP_READ_INTRS,
      OP_READ_ILINE:    cmd_legal = any_st && cp[CAP_PROG_INTR];
      OP_ASSIGN_ILINE:  cmd_legal = cfg_st && cp[CAP_PROG_INTR];
      OP_ASYNC_MODE:    cmd_legal = any_st &&
                                    (cp[CAP_RESP_GEN] || cp[CAP_EVENT_GEN]);
      OP_CTRL_RESPONSE: cmd_legal = any_st && cp[CAP_RESP_GEN];
      OP_CTRL_EVENT:    cmd_legal = any_st && cp[CAP_EVENT_GEN];
      default:          cmd_legal = 1'b0;
    endcase
  endfunction : cmd_legal

  // Masked update of individual enable bits
  function automatic logic [7:0] masked_update(input logic [7:0] cur, input logic [7:0] m,
                                               input logic [7:0] val, input logic [7:0] sup);
    masked_update = (cur & ~(m & sup)) | (val & m & sup);
  endfunction : masked_update

  assign legal = wr_cmd && cmd_legal(op, state, caps);

  // Default configuration derived from current capabilities
  always_comb begin
    dflt              = '0;
    dflt.resp_global  = 1'b1;
    dflt.evt_global   = 1'b1;
    dflt.via_signal   = caps[CAP_MASTER];
    dflt.dest_la      = DEFAULT_DEST_LA;
    dflt.commander_la = DEFAULT_COMMANDER_CAPABILITY_BIT_LA;
    dflt.handler_line = LINE_NONE;
    dflt.intr_line    = LINE_NONE;
    dflt.resp_en      = RESP_EN_RESET;
    dflt.evt_en       = caps[CAP_EVSUP_LSB +: 8];
  end

  // Sub-state sequencing; initialize lasts one cycle and always succeeds
  always_comb begin
    next_state = state;
    case (state)
      ST_CONFIGURE: begin
        if (legal && op == OP_BEGIN_NORMAL) begin
          next_state = ST_INITIALIZE;
        end
      end
      ST_INITIALIZE: begin
        next_state = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (legal && (op == OP_END_NORMAL || op == OP_ABORT_NORMAL)) begin
          next_state = ST_CONFIGURE;
        end
      end
      default: begin
        next_state = ST_CONFIGURE;
      end
    endcase
    if (legal && op == OP_ABORT_NORMAL) begin
      next_state = ST_CONFIGURE;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_CONFIGURE;
    end else begin
      state <= next_state;
    end
  end

  // Capabilities are software programmable so one design covers all variants
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      caps <= CAPS_RESET;
    end else if (i_wr && i_addr == ADDR_CAPS && state == ST_CONFIGURE) begin
      caps <= i_wdata;
    end
  end

  // Stored configuration; reset value mirrors the default of CAPS_RESET
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg              <= '0;
      cfg.resp_global  <= 1'b1;
      cfg.evt_global   <= 1'b1;
      cfg.via_signal   <= CAPS_RESET[CAP_MASTER];
      cfg.dest_la      <= DEFAULT_DEST_LA;
      cfg.commander_la <= DEFAULT_COMMANDER_CAPABILITY_BIT_LA;
      cfg.handler_line <= LINE_NONE;
      cfg.intr_line    <= LINE_NONE;
      cfg.resp_en      <= RESP_EN_RESET;
      cfg.evt_en       <= CAPS_RESET[CAP_EVSUP_LSB +: 8];
    end else if (legal) begin
      case (op)
        OP_ABORT_NORMAL: begin
          cfg <= dflt;
        end
        OP_IDENT_COMMANDER_CAPABILITY_BIT: begin
          cfg.commander_la <= arg;
        end
        OP_ASSIGN_HLINE: begin
          cfg.handler_line <= arg[2:0];
        end
        OP_ASSIGN_ILINE: begin
          cfg.intr_line <= arg[2:0];
        end
        OP_ASYNC_MODE: begin
          cfg.resp_global <= arg[0];
          cfg.evt_global  <= arg[1];
          // Signals need bus mastership
          cfg.via_signal  <= arg[2] && caps[CAP_MASTER];
        end
        OP_CTRL_RESPONSE: begin
          cfg.resp_en <= 7'(masked_update({1'b0, cfg.resp_en}, msk, arg,
                                          {1'b0, caps[CAP_RSSUP_LSB +: 7]}));
        end
        OP_CTRL_EVENT: begin
          cfg.evt_en <= masked_update(cfg.evt_en, msk, arg,
                                      caps[CAP_EVSUP_LSB +: 8]);
        end
        default: begin
        end
      endcase
    end
  end

  // Servant list as a bit per logical address
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 256; i++) begin
        servant_list[i] <= 1'b0;
      end
      servant_count <= COUNT_ZERO;
    end else if (legal && op == OP_ABORT_NORMAL) begin
      for (int i = 0; i < 256; i++) begin
        servant_list[i] <= 1'b0;
      end
      servant_count <= COUNT_ZERO;
    end else if (legal && op == OP_GRANT && !servant_list[arg]) begin
      servant_list[arg] <= 1'b1;
      servant_count     <= servant_count + 9'h001;
    end else if (legal && op == OP_RELEASE && servant_list[arg]) begin
      servant_list[arg] <= 1'b0;
      servant_count     <= servant_count - 9'h001;
    end
  end

  // Protocol error: set by a refused command, cleared when reported
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      perr <= PERR_NONE;
    end else if (wr_cmd && !legal) begin
      perr <= PERR_BAD_CMD;
    end else if (legal && op == OP_READ_PERR) begin
      perr <= PERR_NONE;
    end
  end

  // Reply word for query commands; a new reply wins over a read clear
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reply       <= 16'h0000;
      reply_valid <= 1'b0;
    end else if (legal) begin
      reply_valid <= 1'b1;
      case (op)
        OP_BEGIN_NORMAL:  reply <= 16'h0000;
        OP_READ_PROTO:    reply <= {8'h00, 2'b00, caps[5:0]};
        OP_READ_PERR:     reply <= {8'h00, perr};
        OP_READ_SERVANTS: reply <= {8'h00, caps[CAP_AREA_LSB +: 8]};
        OP_READ_HANDLERS: reply <= {8'h00, NUM_HANDLERS};
        OP_READ_HLINE:    reply <= {13'h0000, cfg.handler_line};
        OP_READ_INTRS:    reply <= {8'h00, NUM_INTRS};
        OP_READ_ILINE:    reply <= {13'h0000, cfg.intr_line};
        default:          reply <= 16'h0000;
      endcase
    end else if (rd_reply) begin
      reply_valid <= 1'b0;
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      if (i_addr == ADDR_REPLY) begin
        o_rdata <= {15'h0000, reply_valid, reply};
      end else if (i_addr == ADDR_STATUS) begin
        o_rdata <= {perr, 4'h0, servant_count, 7'h00, state == ST_NORMAL, state};
      end else if (i_addr == ADDR_CAPS) begin
        o_rdata <= caps;
      end else if (i_addr == ADDR_CONFIG) begin
        o_rdata <= {cfg.commander_la, cfg.dest_la, 1'b0, cfg.via_signal,
                    cfg.evt_global, cfg.resp_global, 1'b0, cfg.intr_line,
                    1'b0, cfg.handler_line, 4'h0};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Active view: loaded every cycle the next state is normal, zero otherwise; o_substate takes next_state every cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_substate           <= ST_CONFIGURE;
      o_activated          <= 1'b0;
      o_accept_incoming    <= 1'b0;
      o_irq_line           <= LINE_NONE;
      o_handler_line       <= LINE_NONE;
      o_deliver_via_signal <= 1'b0;
      o_dest_la            <= DEFAULT_DEST_LA;
      o_resp_gen_en        <= RESP_EN_RESET;
      o_evt_gen_en         <= 8'h00;
    end else begin
      o_substate <= next_state;
      if (next_state == ST_NORMAL) begin
        o_activated          <= 1'b1;
        o_accept_incoming    <= 1'b1;
        o_irq_line           <= cfg.intr_line;
        o_handler_line       <= cfg.handler_line;
        o_deliver_via_signal <= cfg.via_signal;
        o_dest_la            <= cfg.dest_la;
        o_resp_gen_en        <= (cfg.resp_global && caps[CAP_RESP_GEN]) ?
                                cfg.resp_en : 7'h00;
        o_evt_gen_en         <= (cfg.evt_global && caps[CAP_EVENT_GEN]) ?
                                cfg.evt_en : 8'h00;
      end else begin
        // Deactivated outside normal: no lines, no transfers
        o_activated          <= 1'b0;
        o_accept_incoming    <= 1'b0;
        o_irq_line           <= LINE_NONE;
        o_handler_line       <= LINE_NONE;
        o_deliver_via_signal <= 1'b0;
        o_dest_la            <= DEFAULT_DEST_LA;
        o_resp_gen_en        <= 7'h00;
        o_evt_gen_en         <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  a_refused_logs_error: assert property (wr_cmd && !legal |=> perr == PERR_BAD_CMD)
    else $error("refused command did not log protocol error");
  a_configure_quiet: assert property (o_substate != ST_NORMAL |->
    !o_activated && o_irq_line == LINE_NONE && o_evt_gen_en == 8'h00)
    else $error("device active outside normal operation");
  a_begin_sequence: assert property (state == ST_CONFIGURE && legal
    && op == OP_BEGIN_NORMAL |=> state == ST_INITIALIZE ##1 state == ST_NORMAL && o_activated)
    else $error("begin normal operation did not reach normal");
  a_abort_defaults: assert property (legal && op == OP_ABORT_NORMAL |=>
    state == ST_CONFIGURE && cfg.resp_en == RESP_EN_RESET && servant_count == COUNT_ZERO
    && cfg.intr_line == LINE_NONE && cfg.via_signal == caps[CAP_MASTER])
    else $error("abort did not restore default configuration");
  a_grant_adds: assert property (legal && op == OP_GRANT |=> servant_list[$past(arg)])
    else $error("granted address missing from servant list");
  a_release_drops: assert property (legal && op == OP_RELEASE |=>
    !servant_list[$past(arg)])
    else $error("released address still in servant list");
  a_identify_records: assert property (legal && op == OP_IDENT_COMMANDER_CAPABILITY_BIT |=>
    cfg.commander_la == $past(arg))
    else $error("commander address not recorded");
  a_assign_noop_normal: assert property (state == ST_NORMAL && wr_cmd
    && op == OP_ASSIGN_ILINE |=> $stable(cfg.intr_line))
    else $error("interrupter line changed in normal operation");
  a_event_mask: assert property (legal && op == OP_CTRL_EVENT |=>
    (cfg.evt_en & ~caps[CAP_EVSUP_LSB +: 8]) == ($past(cfg.evt_en) & ~caps[CAP_EVSUP_LSB +: 8]))
    else $error("unsupported event enable changed");
  a_perr_clears: assert property (legal && op == OP_READ_PERR |=> perr == PERR_NONE)
    else $error("protocol error not cleared after report");
  // Enables may be set while configuring, yet nothing may go out
  a_config_no_gen: assert property (o_substate == ST_CONFIGURE |->
    o_resp_gen_en == 7'h00 && !o_accept_incoming && !o_deliver_via_signal)
    else $error("generation active in configure");
  a_normal_active: assert property (o_substate == ST_NORMAL |->
    o_activated && o_accept_incoming)
    else $error("normal operation not active");

  c_reach_normal: cover property (state == ST_INITIALIZE ##1 state == ST_NORMAL);
  c_grant_then_begin: cover property (legal && op == OP_GRANT ##[1:20] legal
    && op == OP_BEGIN_NORMAL);
  c_refused: cover property (wr_cmd && !legal);
  c_end_normal: cover property (state == ST_NORMAL && legal && op == OP_END_NORMAL);
  c_misplaced_assign: cover property (state == ST_NORMAL && wr_cmd && op == OP_ASSIGN_ILINE);

endmodule : message_device_config_commands

// File: commander_model.sv
/*
  Commander model: drives commands and register reads into the device.
  Assumes the slave answers a read one cycle later and never stalls.
*/
`timescale 1ns/1ps
module commander_model (
  input  wire logic        i_core_clk,
  input  wire logic [31:0] i_rdata,
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  import msg_cfg_pkg::*;
  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_wr    <= 1'b0;
    // Idle bus never shows a stale value
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask : rd
  task automatic cmd(input logic [7:0] op, input logic [7:0] m, input logic [7:0] arg);
    wr(ADDR_COMMAND, {op, 8'h00, m, arg});
    if (op == OP_BEGIN_NORMAL) begin
      repeat (2) @(posedge i_core_clk);
    end
    #1;
  endtask : cmd
endmodule : commander_model

// File: test_message_device_config_commands.sv
/*
  Self-checking bench for the configuration command block.
  Assumes commander_model as bus master and the package constants.
*/
`timescale 1ns/1ps
module test_message_device_config_commands;
  import msg_cfg_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_reset_n  = 1'b0;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  substate_e   o_substate;
  logic        o_activated;
  logic        o_accept_incoming;
  logic        o_deliver_via_signal;
  logic [2:0]  o_irq_line;
  logic [2:0]  o_handler_line;
  logic [7:0]  o_dest_la;
  logic [6:0]  o_resp_gen_en;
  logic [7:0]  o_evt_gen_en;
  logic [31:0] d;
  int          mismatches = 0;
  int          n_tests    = 0;
  always #5 i_core_clk = ~i_core_clk;
  commander_model commander_capability_bit (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  message_device_config_commands uut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_substate(o_substate), .o_activated(o_activated),
    .o_accept_incoming(o_accept_incoming), .o_irq_line(o_irq_line),
    .o_handler_line(o_handler_line), .o_deliver_via_signal(o_deliver_via_signal),
    .o_dest_la(o_dest_la), .o_resp_gen_en(o_resp_gen_en), .o_evt_gen_en(o_evt_gen_en));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic reg_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    commander_capability_bit.rd(a, d);
    chk(nm, e, d);
  endtask : reg_chk
  task automatic reply_chk(input logic [15:0] v);
    reg_chk("reply", ADDR_REPLY, {15'h0, 1'b1, v});
  endtask : reply_chk
  task automatic t_defaults;
    chk("state", ST_CONFIGURE, o_substate);
    chk("active", 1'b0, o_activated);
    chk("incoming", 1'b0, o_accept_incoming);
    reg_chk("caps", ADDR_CAPS, CAPS_RESET);
    reg_chk("status", ADDR_STATUS, 32'h0000_0001);
    reg_chk("config", ADDR_CONFIG, 32'h0000_7000);
    reg_chk("unmapped", 8'h20, 32'h0);
    commander_capability_bit.cmd(OP_BEGIN_NORMAL, 8'h00, 8'h00);
    chk("normal", ST_NORMAL, o_substate);
    chk("incoming on", 1'b1, o_accept_incoming);
    chk("via signal", 1'b1, o_deliver_via_signal);
    chk("dest", DEFAULT_DEST_LA, o_dest_la);
    chk("events", 8'hFF, o_evt_gen_en);
    chk("responses", RESP_EN_RESET, o_resp_gen_en);
    chk("lines", 6'h00, {o_irq_line, o_handler_line});
    reg_chk("ready", ADDR_STATUS, 32'h0000_000C);
    commander_capability_bit.cmd(OP_ABORT_NORMAL, 8'h00, 8'h00);
    chk("aborted", ST_CONFIGURE, o_substate);
  endtask : t_defaults
  task automatic t_config;
    commander_capability_bit.cmd(OP_IDENT_COMMANDER_CAPABILITY_BIT, 8'h00, 8'h21);
    commander_capability_bit.cmd(OP_GRANT, 8'h00, 8'h05);
    commander_capability_bit.cmd(OP_GRANT, 8'h00, 8'h06);
    commander_capability_bit.cmd(OP_RELEASE, 8'h00, 8'h05);
    commander_capability_bit.cmd(OP_READ_SERVANTS, 8'h00, 8'h00);
    reply_chk(16'h0004);
    commander_capability_bit.cmd(OP_ASSIGN_HLINE, 8'h00, 8'h03);
    commander_capability_bit.cmd(OP_ASSIGN_ILINE, 8'h00, 8'h05);
    reg_chk("servants", ADDR_STATUS, 32'h0000_0801);
    reg_chk("config", ADDR_CONFIG, 32'h2100_7530);
    chk("irq idle", 3'h0, o_irq_line);
    commander_capability_bit.cmd(OP_BEGIN_NORMAL, 8'h00, 8'h00);
    chk("lines", {3'h5, 3'h3}, {o_irq_line, o_handler_line});
    // Deliberate misplaced grant in normal operation
    commander_capability_bit.cmd(OP_GRANT, 8'h00, 8'h07);
    commander_capability_bit.cmd(OP_ASSIGN_ILINE, 8'h00, 8'h02);
    reg_chk("perr", ADDR_STATUS, 32'h0100_080C);
    commander_capability_bit.cmd(OP_READ_PERR, 8'h00, 8'h00);
    reply_chk(16'h0001);
    reg_chk("perr clr", ADDR_STATUS, 32'h0000_080C);
    commander_capability_bit.cmd(OP_END_NORMAL, 8'h00, 8'h00);
    reg_chk("kept", ADDR_CONFIG, 32'h2100_7530);
    commander_capability_bit.cmd(OP_ABORT_NORMAL, 8'h00, 8'h00);
    reg_chk("default", ADDR_CONFIG, 32'h0000_7000);
    reg_chk("empty", ADDR_STATUS, 32'h0000_0001);
  endtask : t_config
  task automatic t_generation;
    commander_capability_bit.cmd(OP_CTRL_RESPONSE, 8'h0F, 8'h05);
    commander_capability_bit.cmd(OP_CTRL_EVENT, 8'hF0, 8'h30);
    commander_capability_bit.cmd(OP_ASYNC_MODE, 8'h00, 8'h03);
    reg_chk("async", ADDR_CONFIG, 32'h0000_3000);
    commander_capability_bit.cmd(OP_BEGIN_NORMAL, 8'h00, 8'h00);
    chk("resp en", 7'h05, o_resp_gen_en);
    chk("evt en", 8'h3F, o_evt_gen_en);
    chk("via", 1'b0, o_deliver_via_signal);
    // Hard reset in mid-run must also restore defaults
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    #1;
    chk("reset state", ST_CONFIGURE, o_substate);
    reg_chk("reset cfg", ADDR_CONFIG, 32'h0000_7000);
  endtask : t_generation
  task automatic t_core;
    for (int s = 0; s < 2; s++) begin
      commander_capability_bit.cmd(OP_READ_PROTO, 8'h00, 8'h00);
      reply_chk(16'h003F);
      commander_capability_bit.cmd(OP_CLEAR, 8'h00, 8'h00);
      reply_chk(16'h0000);
      commander_capability_bit.cmd(OP_BEGIN_NORMAL, 8'h00, 8'h00);
    end
    chk("still normal", ST_NORMAL, o_substate);
  endtask : t_core
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    t_defaults();
    t_config();
    t_generation();
    t_core();
    stop_test();
  end
  // Whole run is about 110 cycles; this leaves wide margin
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule : test_message_device_config_commands
